// ---- logic/tpcw_ctrl.sv ----
// transmit packet control word capture, per-frame control and event interrupts
// Notes on behaviour
// - hold frame until preload byte count is loaded, then start toward phy.
// - 9-bit tag from control word is reported with frame's status entry.
// - non-zero ip header offset asks transmitter to fix header checksum.
// - append-crc bit makes transmitter compute and append frame check.
// - fix-crc bit makes transmitter replace existing frame check sequence.
// - disable-padding sends short frames unpadded; otherwise pad to 64 bytes.
// - late-notify raises interrupt when frame transmission completes.
// - early-notify raises interrupt when frame transmission begins.
// - excessive-collision bit raises interrupt on abort by excessive collisions.
// - one bit disables deferral timeout, another selects fast back-off.
`timescale 1ns/1ps
module tpcw_ctrl
	import tpcw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [15:0] fifo_bytes,
	input wire logic tx_started,
	input wire logic tx_done,
	input wire logic tx_xcol,
	output logic frame_valid,
	output logic tx_go,
	output logic [15:0] frame_len,
	output logic [8:0] frame_tag,
	output logic [5:0] ip_hdr_offset,
	output logic ip_csum_fix,
	output logic append_crc,
	output logic fix_crc,
	output logic pad_enable,
	output logic [15:0] pad_to_len,
	output logic defer_timeout_off,
	output logic fast_backoff,
	output logic status_push,
	output logic [8:0] status_tag,
	output logic irq
);
	logic wr_pend_r;
	logic [11:0] addr_r;
	logic [31:0] cmd_r;
	logic [15:0] len_r;
	logic [31:0] act_r;
	logic [15:0] len_act_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_en_r;
	logic [2:0] ev;
	logic [2:0] clr;
	logic setup_wr;
	logic [4:0] preload;

	typedef enum logic [1:0] {TPCW_IDLE, TPCW_LOAD, TPCW_SEND} tpcw_state_e;
	tpcw_state_e state_r;

	// write request pending in the data phase; the slave is always ready
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
		end else if (hready) begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
		end else begin
			wr_pend_r <= 1'b0;
		end
	end

	// address of the transfer now in its data phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_r <= 12'h000;
		end else if (hready) begin
			addr_r <= haddr;
		end
	end

	// ready: no wait states
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// response: always okay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// strobes decoded in the data phase
	assign setup_wr = wr_pend_r && (addr_r == ADDR_SETUP);
	assign clr = (wr_pend_r && addr_r == ADDR_IRQ_CLR) ? hwdata[2:0] : IRQ_RESET;

	// staging copy of the control word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_r <= CMD_RESET;
		end else if (wr_pend_r && addr_r == ADDR_CMD) begin
			cmd_r <= hwdata;
		end
	end

	// staging copy of the frame length
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_r <= LEN_RESET;
		end else if (wr_pend_r && addr_r == ADDR_LEN) begin
			len_r <= hwdata[15:0];
		end
	end

	// interrupt enable register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_en_r <= IRQ_RESET;
		end else if (wr_pend_r && addr_r == ADDR_IRQ_EN) begin
			irq_en_r <= hwdata[2:0];
		end
	end

	// read data: write-only words read as zero
	always_ff @(posedge clk) begin
		if (!rst_n)
			hrdata <= BUS_ZERO;
		else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				ADDR_IRQ_STAT: hrdata <= {29'h0, irq_stat_r};
				ADDR_IRQ_EN: hrdata <= {29'h0, irq_en_r};
				ADDR_TXSTAT: hrdata <= {14'h0, state_r, 7'h00, act_r[TAG_HI:TAG_LO]};
				ADDR_CMD, ADDR_LEN, ADDR_SETUP, ADDR_IRQ_CLR: hrdata <= BUS_ZERO;
				default: hrdata <= BUS_ZERO;
			endcase
		end
	end

	// setup trigger latches the staged word for this frame alone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_r <= CMD_RESET;
		end else if (setup_wr && state_r == TPCW_IDLE) begin
			act_r <= cmd_r;
		end
	end

	// setup trigger latches the staged length with it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			len_act_r <= LEN_RESET;
		end else if (setup_wr && state_r == TPCW_IDLE) begin
			len_act_r <= len_r;
		end
	end

	assign preload = act_r[PRELOAD_HI:PRELOAD_LO];

	// frame sequencing: wait for preload, send, finish
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= TPCW_IDLE;
			tx_go <= 1'b0;
			frame_valid <= 1'b0;
		end else begin
			unique case (state_r)
				TPCW_IDLE: begin
					// a setup write starts a frame
					tx_go <= 1'b0;
					if (setup_wr) begin
						state_r <= TPCW_LOAD;
						frame_valid <= 1'b1;
					end
				end
				TPCW_LOAD: begin
					// wait until the preload bytes are in the fifo
					if (fifo_bytes >= {11'h000, preload}) begin
						state_r <= TPCW_SEND;
						tx_go <= 1'b1;
					end
				end
				TPCW_SEND: begin
					// end on completion or collision abort
					if (tx_done || tx_xcol) begin
						state_r <= TPCW_IDLE;
						tx_go <= 1'b0;
						frame_valid <= 1'b0;
					end
				end
			endcase
		end
	end

	// frame length toward the transmitter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_len <= LEN_RESET;
		end else begin
			frame_len <= len_act_r;
		end
	end

	// packet tag toward the transmitter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_tag <= 9'h000;
		end else begin
			frame_tag <= act_r[TAG_HI:TAG_LO];
		end
	end

	// ip header offset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ip_hdr_offset <= 6'h00;
		end else begin
			ip_hdr_offset <= act_r[IPOFF_HI:IPOFF_LO];
		end
	end

	// header checksum fix asked for by a non-zero offset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ip_csum_fix <= 1'b0;
		end else begin
			ip_csum_fix <= act_r[IPOFF_HI:IPOFF_LO] != 6'h00;
		end
	end

	// append frame check sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			append_crc <= 1'b0;
		end else begin
			append_crc <= act_r[BIT_APPEND_CRC];
		end
	end

	// replace frame check sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fix_crc <= 1'b0;
		end else begin
			fix_crc <= act_r[BIT_FIX_CRC];
		end
	end

	// padding of short frames
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_enable <= 1'b1;
		end else begin
			pad_enable <= !act_r[BIT_NO_PAD];
		end
	end

	// length on the wire after padding, aligned with frame_len
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_to_len <= MIN_FRAME;
		end else begin
			pad_to_len <= (!act_r[BIT_NO_PAD] && len_act_r < MIN_FRAME) ? MIN_FRAME : len_act_r;
		end
	end

	// deferral timeout off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			defer_timeout_off <= 1'b0;
		end else begin
			defer_timeout_off <= act_r[BIT_NO_DEFER_TO];
		end
	end

	// fast back-off timer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fast_backoff <= 1'b0;
		end else begin
			fast_backoff <= act_r[BIT_FAST_BACKOFF];
		end
	end

	// status fifo push when the frame ends
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_push <= 1'b0;
		end else begin
			status_push <= state_r == TPCW_SEND && (tx_done || tx_xcol);
		end
	end

	// status fifo entry carries the frame tag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_tag <= 9'h000;
		end else begin
			status_tag <= act_r[TAG_HI:TAG_LO];
		end
	end

	// event strobes, counted only while sending
	always_comb begin
		ev = IRQ_RESET;
		if (state_r == TPCW_SEND && tx_started && act_r[BIT_EARLY_NOTIFY])
			ev[IRQ_START] = 1'b1;
		if (state_r == TPCW_SEND && tx_done && act_r[BIT_LATE_NOTIFY])
			ev[IRQ_DONE] = 1'b1;
		if (state_r == TPCW_SEND && tx_xcol && act_r[BIT_XCOL_IRQ])
			ev[IRQ_XCOL] = 1'b1;
	end

	// sticky status, set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_r <= IRQ_RESET;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
		end
	end

	// level interrupt from enabled sticky bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
		end
	end
endmodule : tpcw_ctrl

// ---- logic/tpcw_pkg.sv ----
// constants for the transmit packet control word block
package tpcw_pkg;
	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_LEN = 12'h004;
	localparam logic [11:0] ADDR_SETUP = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h020;
	localparam logic [11:0] ADDR_IRQ_EN = 12'h024;
	localparam logic [11:0] ADDR_IRQ_CLR = 12'h028;
	localparam logic [11:0] ADDR_TXSTAT = 12'h02c;
	localparam int PRELOAD_HI = 29;
	localparam int PRELOAD_LO = 25;
	localparam int TAG_HI = 24;
	localparam int TAG_LO = 16;
	localparam int IPOFF_HI = 15;
	localparam int IPOFF_LO = 10;
	localparam int BIT_APPEND_CRC = 9;
	localparam int BIT_FIX_CRC = 8;
	localparam int BIT_NO_PAD = 6;
	localparam int BIT_LATE_NOTIFY = 5;
	localparam int BIT_EARLY_NOTIFY = 4;
	localparam int BIT_XCOL_IRQ = 3;
	localparam int BIT_NO_DEFER_TO = 2;
	localparam int BIT_FAST_BACKOFF = 1;
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;
	localparam logic [15:0] LEN_RESET = 16'h0000;
	localparam logic [15:0] MIN_FRAME = 16'h0040;
	localparam int IRQ_START = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_XCOL = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
endpackage : tpcw_pkg

// ---- test/tpcw_tx_model.sv ----
// behavioural transmitter facing the control block
`timescale 1ns/1ps
module tpcw_tx_model(
	input wire logic clk,
	input wire logic frame_valid,
	input wire logic tx_go,
	input wire logic xcol_mode,
	output logic [15:0] fifo_bytes,
	output logic tx_started,
	output logic tx_done,
	output logic tx_xcol
);
	logic [3:0] t_r;
	initial {fifo_bytes, t_r, tx_started, tx_done, tx_xcol} = 23'h0;
	always @(posedge clk) begin
		if (!tx_go) fifo_bytes <= frame_valid ? fifo_bytes + 16'h1 : 16'h0;
		t_r <= tx_go ? t_r + 4'h1 : 4'h0;
		tx_started <= tx_go && t_r == 4'h2;
		tx_done <= tx_go && t_r == 4'h8 && !xcol_mode;
		tx_xcol <= tx_go && t_r == 4'h8 && xcol_mode;
	end
endmodule : tpcw_tx_model

// ---- test/tpcw_ctrl_assertions.sv ----
// assertions on the control block ports
`timescale 1ns/1ps
module tpcw_chk(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_done,
	input wire logic tx_xcol,
	input wire logic frame_valid,
	input wire logic tx_go,
	input wire logic [15:0] frame_len,
	input wire logic [5:0] ip_hdr_offset,
	input wire logic ip_csum_fix,
	input wire logic pad_enable,
	input wire logic [15:0] pad_to_len,
	input wire logic status_push
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_csum_fix: assert property (ip_csum_fix == |ip_hdr_offset) else $error("csum");
	a_pad_short: assert property (pad_enable && frame_len < 16'h40 |-> pad_to_len == 16'h40)
		else $error("pad");
	a_pad_off: assert property (!pad_enable |-> pad_to_len == frame_len) else $error("len");
	a_go_frame: assert property (tx_go |-> frame_valid) else $error("go");
	a_go_stop: assert property (tx_go && tx_xcol |=> !tx_go) else $error("stop");
	a_frame_hold: assert property (frame_valid && !tx_done && !tx_xcol |=> frame_valid)
		else $error("hold");
	a_push_end: assert property (tx_go && (tx_done || tx_xcol) |=> status_push)
		else $error("push");
	a_push_once: assert property (status_push |=> !status_push) else $error("push2");
	c_push: cover property (status_push);
	c_go: cover property ($rose(tx_go));
	c_short: cover property (pad_enable && frame_len < 16'h40);
endmodule : tpcw_chk
bind tpcw_ctrl tpcw_chk u_tpcw_chk(.*);

// ---- test/tpcw_ctrl_tb.sv ----
// self-checking bench for the transmit packet control word block
`timescale 1ns/1ps
`define CHK(n,e,s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
`define WAIT(c) begin n = 0; do begin @(posedge clk); n++; end while (!(c) && n < 300); \
if (!(c)) miscompares++; @(negedge clk); end
module tpcw_ctrl_tb
	import tpcw_pkg::*;
();
	logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, xm = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [11:0] haddr = 12'h0;
	logic [31:0] hwdata = 32'h0, hrdata, q, cmd, rs = 32'h1c64;
	logic [15:0] fifo_bytes, len, frame_len, pad_to_len;
	logic [8:0] frame_tag, status_tag;
	logic [5:0] ip_hdr_offset;
	logic [2:0] en, ex;
	logic hreadyout, hresp, tx_started, tx_done, tx_xcol, frame_valid, tx_go, ip_csum_fix;
	logic append_crc, fix_crc, pad_enable, defer_timeout_off, fast_backoff, status_push, irq;
	int miscompares = 0, total_checks = 0, cyc = 0, n;
	tpcw_ctrl u_tpcw_ctrl(.*, .hsize(3'h2), .hready(hreadyout));
	tpcw_tx_model u_tpcw_tx_model(.*, .xcol_mode(xm));
	always #2.5 clk = ~clk;
	always @(posedge clk) if (++cyc == 20000) begin miscompares++; end_of_test(); end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		if (clk !== 1'h1) @(posedge clk);
		{hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
		do @(posedge clk); while (hreadyout !== 1'h1);
		{hsel, htrans, hwdata} <= {3'h0, d};
		do @(posedge clk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask : bus
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		bus(1'h0, ADDR_CMD, 32'h0);
		`CHK("cmd rd", 32'h0, q)
		bus(1'h0, 12'h100, 32'h0);
		`CHK("unmapped", 32'h0, q)
		for (int i = 0; i < 12; i++) begin
			cmd = xs() & 32'h3fff_ff7e;
			if (i < 2) cmd[29:25] = i ? 5'h1f : 5'h0;
			len = 16'(xs() & 32'h7f);
			en = 3'(xs());
			xm <= rs[7];
			bus(1'h1, ADDR_IRQ_EN, {29'h0, en});
			bus(1'h0, ADDR_IRQ_EN, 32'h0);
			`CHK("en", {29'h0, en}, q)
			bus(1'h1, ADDR_CMD, cmd);
			bus(1'h1, ADDR_LEN, {16'h0, len});
			bus(1'h1, ADDR_SETUP, xs());
			`WAIT(frame_valid)
			`CHK("tag", cmd[24:16], frame_tag)
			`CHK("crc", cmd[15:8], {ip_hdr_offset, append_crc, fix_crc})
			`CHK("csum", |cmd[15:10], ip_csum_fix)
			`CHK("pad en", !cmd[6], pad_enable)
			`CHK("pad", (!cmd[6] && len < 16'h40) ? 16'h40 : len, pad_to_len)
			`CHK("mac", {cmd[2:1], len}, {defer_timeout_off, fast_backoff, frame_len})
			`WAIT(tx_go)
			`CHK("preload", 1'h1, fifo_bytes >= cmd[29:25])
			`WAIT(status_push)
			`CHK("st tag", cmd[24:16], status_tag)
			bus(1'h0, ADDR_TXSTAT, 32'h0);
			`CHK("txstat", {23'h0, cmd[24:16]}, q)
			ex = {cmd[3] & xm, cmd[5] & !xm, cmd[4]};
			bus(1'h0, ADDR_IRQ_STAT, 32'h0);
			`CHK("stat", {29'h0, ex}, q)
			`CHK("irq", |(ex & en), irq)
			bus(1'h1, ADDR_IRQ_CLR, 32'h7);
			bus(1'h0, ADDR_IRQ_STAT, 32'h0);
			`CHK("clr", 32'h0, q)
		end
		`CHK("hresp", 1'h0, hresp)
		end_of_test();
	end
endmodule : tpcw_ctrl_tb
